// *** rtl/boot_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module boot_seq
  import boot_seq_pkg::*;
#(
  parameter int unsigned BIST_DONE_R4  = BIST_DONE_R4_CYC,
  parameter int unsigned BIST_DONE_R15 = BIST_DONE_R15_CYC,
  parameter int unsigned SROM_BITS     = SROM_BITS_DEFAULT
) (
  // clocks and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_srom_clk,
  // asynchronous pins
  input  wire logic                 i_ext_reset_b,
  input  wire logic                 i_power_good,
  input  wire logic [2:0]           i_clk_mode,
  input  wire logic [3:0]           i_irq,
  input  wire logic                 i_srom_present_b,
  input  wire logic                 i_halt_req,
  input  wire logic                 i_pwr_fail_req,
  input  wire logic                 i_mcheck_req,
  // serial boot rom link, on the link clock
  input  wire logic                 i_srom_data,
  output logic                      o_srom_clk_out,
  output logic                      o_srom_oe_b,
  // cache control sources from the core
  input  wire logic [5:0]           i_bc_ctl,
  input  wire logic                 i_tag_dirty,
  input  wire logic                 i_tag_valid,
  input  wire logic                 i_bcast_or_sys,
  // status and configuration
  output boot_seq_pkg::clk_cfg_t    o_clk_cfg,
  output boot_seq_pkg::seq_state_t  o_state,
  output logic                      o_core_reset_b,
  output logic                      o_system_clock_output_rst,
  output logic [2:0]                o_sync_reqs,
  output logic [5:0]                o_bc_ctl,
  output logic                      o_tag_dirty,
  output logic                      o_tag_dirty_oe_b,
  output logic                      o_tag_valid,
  output logic                      o_tag_valid_oe_b,
  // boot words out
  output logic                      o_word_valid,
  input  wire logic                 i_word_ready,
  output boot_seq_pkg::boot_word_t  o_word
);
  localparam int unsigned BIT_CNT_W = $clog2(SROM_BITS + 1);

  logic [1:0]          ext_rst_s;
  logic [1:0]          pgood_s;
  logic [1:0]          present_s;
  logic [2:0]          mode_s1, mode_s2;
  logic [3:0]          irq_s1, irq_s2;
  logic [2:0]          req_s1, req_s2;
  seq_state_t          state_q;
  logic [BIST_CNT_W-1:0] bist_cnt_q;
  logic [BIST_CNT_W-1:0] bist_end;
  logic                released;
  logic                ext_rel_q;
  logic [3:0]          ratio_q;
  logic                load_go_q;
  logic                bist_done;

  // link side
  logic [1:0]          go_l;
  logic                lnk_active_q;
  logic                lnk_clk_q;
  logic [BIT_CNT_W-1:0] lnk_bits_q;
  logic [7:0]          lnk_sh_q;
  logic [2:0]          lnk_bc_q;
  logic                lnk_tgl_q;
  logic [7:0]          lnk_byte_q;
  logic                lnk_last_q;
  logic                lnk_done_q;
  logic [2:0]          tgl_s;
  logic [1:0]          done_s;
  logic                word_pend_q;
  boot_word_t          word_q;
  logic                buf_ready;

  // two-stage synchronisers for pins from outside the domain
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ext_rst_s <= 2'h0;
      pgood_s   <= 2'h0;
      present_s <= 2'h3;
      mode_s1   <= 3'h0;
      mode_s2   <= 3'h0;
      irq_s1    <= 4'h0;
      irq_s2    <= 4'h0;
      req_s1    <= 3'h0;
      req_s2    <= 3'h0;
    end else begin
      ext_rst_s <= {ext_rst_s[0], i_ext_reset_b};
      pgood_s   <= {pgood_s[0], i_power_good};
      present_s <= {present_s[0], i_srom_present_b};
      mode_s1   <= i_clk_mode;
      mode_s2   <= mode_s1;
      irq_s1    <= i_irq;
      irq_s2    <= irq_s1;
      req_s1    <= {i_mcheck_req, i_pwr_fail_req, i_halt_req};
      req_s2    <= req_s1;
    end
  end

  // request lines pass the synchroniser whether driven sync or async
  assign o_sync_reqs = req_s2;

  // clock mode decode
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_clk_cfg                 <= '0;
      o_system_clock_output_rst <= 1'b1;
    end else begin
      o_clk_cfg.pll_mode       <= (mode_s2[2:1] == CLKMODE_PLL_HI);
      o_clk_cfg.direct_mode    <= (mode_s2[2:1] == CLKMODE_DIRECT_HI);
      o_clk_cfg.equalizer_en   <= mode_s2[0] && !(mode_s2[2:1] == CLKMODE_PLL_HI);
      o_clk_cfg.clkout_gen_rst <= mode_s2[1];
      o_clk_cfg.ratio          <= ratio_q;
      o_system_clock_output_rst <= mode_s2[1];
    end
  end

  // release of external reset while power is good
  assign released = ext_rst_s[1] && pgood_s[1];

  // ratio captured from interrupt lines at the release edge
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ext_rel_q <= 1'b0;
      ratio_q   <= RATIO_RESET_VAL;
    end else begin
      ext_rel_q <= released;
      if (released && !ext_rel_q) begin
        ratio_q <= irq_s2;
      end
    end
  end

  // completion point of self-test, by ratio
  assign bist_end  = (ratio_q == RATIO_15) ? BIST_CNT_W'(BIST_DONE_R15)
                                           : BIST_CNT_W'(BIST_DONE_R4);
  assign bist_done = (state_q == ST_BIST) && (bist_cnt_q == bist_end);

  // sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_q    <= ST_RESET;
      bist_cnt_q <= '0;
      load_go_q  <= 1'b0;
    end else if (!released) begin
      state_q    <= ST_RESET;
      bist_cnt_q <= '0;
      load_go_q  <= 1'b0;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          state_q    <= ST_BIST;
          bist_cnt_q <= '0;
        end
        ST_BIST: begin
          bist_cnt_q <= bist_cnt_q + 1'b1;
          if (bist_done) begin
            if (!present_s[1]) begin
              state_q   <= ST_LOAD;
              load_go_q <= 1'b1;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_LOAD: begin
          if (done_s[1]) begin
            state_q   <= ST_RUN;
            load_go_q <= 1'b0;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  assign o_state        = state_q;
  assign o_core_reset_b = (state_q == ST_RUN);

  // load request crosses as a level
  always_ff @(posedge i_srom_clk) begin
    if (!i_rst_b) begin
      go_l <= 2'h0;
    end else begin
      go_l <= {go_l[0], load_go_q};
    end
  end

  // link engine: the link clock ticks twice per cpu bit slot of 126 cycles, once per serial clock phase
  always_ff @(posedge i_srom_clk) begin
    if (!i_rst_b) begin
      lnk_active_q <= 1'b0;
      lnk_clk_q    <= 1'b0;
      lnk_bits_q   <= '0;
      lnk_sh_q     <= 8'h00;
      lnk_bc_q     <= 3'h0;
      lnk_tgl_q    <= 1'b0;
      lnk_byte_q   <= 8'h00;
      lnk_last_q   <= 1'b0;
      lnk_done_q   <= 1'b0;
    end else if (!go_l[1]) begin
      lnk_active_q <= 1'b0;
      lnk_clk_q    <= 1'b0;
      lnk_bits_q   <= '0;
      lnk_bc_q     <= 3'h0;
      lnk_done_q   <= 1'b0;
    end else if (!lnk_done_q) begin
      lnk_active_q <= 1'b1;
      lnk_clk_q    <= ~lnk_clk_q;
      if (lnk_clk_q) begin
        // sample on the falling phase, rom has had half a slot (one phase)
        lnk_sh_q   <= {lnk_sh_q[6:0], i_srom_data};
        lnk_bc_q   <= lnk_bc_q + 3'h1;
        lnk_bits_q <= lnk_bits_q + 1'b1;
        if (lnk_bc_q == 3'h7) begin
          lnk_byte_q <= {lnk_sh_q[6:0], i_srom_data};
          lnk_last_q <= (lnk_bits_q == BIT_CNT_W'(SROM_BITS - 1));
          lnk_tgl_q  <= ~lnk_tgl_q;
        end
        if (lnk_bits_q == BIT_CNT_W'(SROM_BITS - 1)) begin
          lnk_done_q <= 1'b1;
        end
      end
    end
  end

  assign o_srom_clk_out = lnk_clk_q;
  assign o_srom_oe_b    = !lnk_active_q;

  // byte toggle and done level back into the system domain
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      tgl_s  <= 3'h0;
      done_s <= 2'h0;
    end else begin
      tgl_s  <= {tgl_s[1:0], lnk_tgl_q};
      done_s <= {done_s[0], lnk_done_q && word_pend_q == 1'b0};
    end
  end

  // capture each byte once; byte register is stable for a full slot
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      word_pend_q <= 1'b0;
      word_q      <= '0;
    end else begin
      if (tgl_s[2] != tgl_s[1]) begin
        word_pend_q <= 1'b1;
        word_q.data <= lnk_byte_q;
        word_q.last <= lnk_last_q;
      end else if (buf_ready) begin
        word_pend_q <= 1'b0;
      end
    end
  end

  boot_word_buf #(
    .W ($bits(boot_word_t))
  ) u_buf (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (word_pend_q),
    .o_in_ready  (buf_ready),
    .i_in_data   (word_q),
    .o_out_valid (o_word_valid),
    .i_out_ready (i_word_ready),
    .o_out_data  (o_word)
  );

  // cache ram controls registered on the cpu clock in every mode
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_bc_ctl         <= 6'h3f;
      o_tag_dirty      <= 1'b0;
      o_tag_valid      <= 1'b0;
      o_tag_dirty_oe_b <= 1'b1;
      o_tag_valid_oe_b <= 1'b1;
    end else begin
      o_bc_ctl         <= i_bc_ctl;
      o_tag_dirty      <= i_tag_dirty;
      o_tag_valid      <= i_tag_valid;
      o_tag_dirty_oe_b <= !i_bcast_or_sys;
      o_tag_valid_oe_b <= !i_bcast_or_sys;
    end
  end

  // assertions
  a_core_rst_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_q == ST_LOAD |-> !o_core_reset_b) else $error("core reset released during load");
  a_bist_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_q == ST_RESET && released |=> state_q == ST_BIST) else $error("self-test not started");
  a_bist_norom: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    bist_done && present_s[1] && released |=> o_core_reset_b) else $error("no release after self-test");
  a_bist_rom: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    bist_done && !present_s[1] && released |=> state_q == ST_LOAD) else $error("load not started");
  a_bist_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_q == ST_BIST && bist_cnt_q == '0 && released && ratio_q != RATIO_15
    |-> ##1 (state_q == ST_BIST) [*6]) else $error("self-test ended early");
  a_clk_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    mode_s2[1] |=> o_system_clock_output_rst) else $error("clock output not held");
  a_pll_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    mode_s2[2:1] == CLKMODE_PLL_HI |=> o_clk_cfg.pll_mode && !o_clk_cfg.equalizer_en)
    else $error("pll decode wrong");
  a_direct_eq: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    mode_s2 == 3'h5 |=> o_clk_cfg.direct_mode && o_clk_cfg.equalizer_en)
    else $error("direct decode wrong");
  a_tag_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !i_bcast_or_sys |=> o_tag_valid_oe_b && o_tag_dirty_oe_b) else $error("tags driven out");
  a_srom_clk: assert property (@(posedge i_srom_clk) disable iff (!i_rst_b)
    lnk_active_q && !lnk_done_q && go_l[1] |=> o_srom_clk_out != $past(o_srom_clk_out))
    else $error("serial clock stalled");

endmodule
`default_nettype wire

// *** rtl/boot_seq_pkg.sv ***
package boot_seq_pkg;

  // self-test timeline, system cycles from the first edge after release
  localparam int unsigned BIST_FIRST_EVT_CYC = 7;
  localparam int unsigned BIST_DONE_R4_CYC   = 28570;
  localparam int unsigned BIST_DONE_R15_CYC  = 15750;
  localparam int unsigned BIST_CNT_W         = 16;

  // serial boot clock, cpu cycles per bit
  localparam int unsigned SROM_BIT_CPU_CYC   = 126;
  localparam int unsigned SROM_SETUP_FACTOR  = 5;
  localparam int unsigned SROM_BITS_DEFAULT  = 64;
  localparam int unsigned SROM_HALF_LINK_CYC = 1;

  // clock ratio codes taken from the interrupt lines
  localparam logic [3:0]  RATIO_4            = 4'h4;
  localparam logic [3:0]  RATIO_15           = 4'hf;
  localparam logic [3:0]  RATIO_RESET_VAL    = 4'h4;

  // clock mode select encodings
  localparam logic [1:0]  CLKMODE_PLL_HI     = 2'h0;
  localparam logic [1:0]  CLKMODE_DIRECT_HI  = 2'h2;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_BIST  = 3'h1,
    ST_LOAD  = 3'h2,
    ST_RUN   = 3'h3
  } seq_state_t;

  // decoded clock configuration
  typedef struct packed {
    logic       pll_mode;
    logic       direct_mode;
    logic       equalizer_en;
    logic       clkout_gen_rst;
    logic [3:0] ratio;
  } clk_cfg_t;

  // one word assembled from the serial boot stream
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } boot_word_t;

endpackage

// *** rtl/boot_word_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer between the load engine and the consumer
module boot_word_buf #(
  parameter int unsigned W = 9
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  // fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  logic [W-1:0] mem_q [2];
  logic         wr_q;
  logic         rd_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  // handshakes
  assign o_in_ready  = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_q[rd_q];

  // storage
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule
`default_nettype wire

// *** tb/boot_seq_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module boot_seq_bench;
  import boot_seq_pkg::*;
  typedef struct packed {
    logic [2:0] mode;
    logic [5:0] bc;
    logic       bcast;
    logic [2:0] req;
    logic       pll;
    logic       direct;
    logic       gen_rst;
  } row_t;
  localparam row_t ROWS [8] = '{
    '{3'h0, 6'h15, 1'b1, 3'h1, 1'b1, 1'b0, 1'b0}, '{3'h1, 6'h2a, 1'b0, 3'h2, 1'b1, 1'b0, 1'b0},
    '{3'h4, 6'h00, 1'b1, 3'h4, 1'b0, 1'b1, 1'b0}, '{3'h5, 6'h3f, 1'b0, 3'h7, 1'b0, 1'b1, 1'b0},
    '{3'h2, 6'h01, 1'b1, 3'h0, 1'b0, 1'b0, 1'b1}, '{3'h3, 6'h3e, 1'b0, 3'h5, 1'b0, 1'b0, 1'b1},
    '{3'h6, 6'h0c, 1'b1, 3'h3, 1'b0, 1'b0, 1'b1}, '{3'h7, 6'h33, 1'b0, 3'h6, 1'b0, 1'b0, 1'b1}};
  logic       i_sys_clk, i_rst_b, link_clk, i_ext_reset_b, i_power_good, i_srom_present_b;
  logic [2:0] i_clk_mode;
  logic [3:0] i_irq;
  logic [5:0] i_bc_ctl;
  logic       i_halt_req, i_pwr_fail_req, i_mcheck_req, i_tag_dirty, i_tag_valid;
  logic       i_bcast_or_sys, i_word_ready, rom_data, o_srom_clk_out, o_srom_oe_b;
  logic       o_core_reset_b, o_system_clock_output_rst, o_tag_dirty, o_tag_dirty_oe_b;
  logic       o_tag_valid, o_tag_valid_oe_b, o_word_valid;
  logic [2:0] o_sync_reqs;
  logic [5:0] o_bc_ctl;
  clk_cfg_t   o_clk_cfg;
  seq_state_t o_state;
  boot_word_t o_word;
  boot_word_t got_q[$];
  int         n_errors, comparisons;

  boot_seq #(.BIST_DONE_R4(40), .BIST_DONE_R15(30), .SROM_BITS(16)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_srom_clk(link_clk),
    .i_ext_reset_b(i_ext_reset_b), .i_power_good(i_power_good), .i_clk_mode(i_clk_mode),
    .i_irq(i_irq), .i_srom_present_b(i_srom_present_b), .i_halt_req(i_halt_req),
    .i_pwr_fail_req(i_pwr_fail_req), .i_mcheck_req(i_mcheck_req), .i_srom_data(rom_data),
    .o_srom_clk_out(o_srom_clk_out), .o_srom_oe_b(o_srom_oe_b), .i_bc_ctl(i_bc_ctl),
    .i_tag_dirty(i_tag_dirty), .i_tag_valid(i_tag_valid), .i_bcast_or_sys(i_bcast_or_sys),
    .o_clk_cfg(o_clk_cfg), .o_state(o_state), .o_core_reset_b(o_core_reset_b),
    .o_system_clock_output_rst(o_system_clock_output_rst), .o_sync_reqs(o_sync_reqs),
    .o_bc_ctl(o_bc_ctl), .o_tag_dirty(o_tag_dirty), .o_tag_dirty_oe_b(o_tag_dirty_oe_b),
    .o_tag_valid(o_tag_valid), .o_tag_valid_oe_b(o_tag_valid_oe_b),
    .o_word_valid(o_word_valid), .i_word_ready(i_word_ready), .o_word(o_word));

  srom_model #(.NBITS(16), .IMAGE(16'ha53c)) rom (
    .i_link_clk(link_clk), .i_rom_clk(o_srom_clk_out), .i_rom_oe_b(o_srom_oe_b),
    .o_rom_data(rom_data));

  // clocks: link clock unrelated in phase
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #32 link_clk = ~link_clk;
  end

  // collect words accepted on the drain side
  always @(posedge i_sys_clk) begin
    if (o_word_valid === 1'b1 && i_word_ready === 1'b1) got_q.push_back(o_word);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one power-up pass from external reset release to run
  task automatic boot(input logic [3:0] ratio, input logic rom_b, input int bist);
    int n;
    int tog;
    logic last_clk;
    @(negedge i_sys_clk);
    i_ext_reset_b    = 1'b0;
    i_irq            = ratio;
    i_srom_present_b = rom_b;
    i_word_ready     = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    i_ext_reset_b = 1'b1;
    n = 0;
    while (o_state !== ST_BIST && n < 20) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(16'(n <= 4), 16'h1);
    repeat (bist - 2) begin
      @(negedge i_sys_clk);
      chk({o_core_reset_b, 12'h0, o_state}, {1'b0, 12'h0, ST_BIST});
    end
    chk(16'(o_clk_cfg.ratio), 16'(ratio));
    n = 0;
    while (o_state === ST_BIST && n < 5) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(16'(o_state), rom_b ? 16'(ST_RUN) : 16'(ST_LOAD));
    tog = 0;
    n = 0;
    last_clk = o_srom_clk_out;
    while (o_state === ST_LOAD && n < 3000) begin
      chk(16'(o_core_reset_b), 16'h0);
      @(negedge i_sys_clk);
      if (o_srom_clk_out !== last_clk) tog++;
      last_clk = o_srom_clk_out;
      n++;
    end
    if (!rom_b) chk(16'(tog >= 32), 16'h1);
    // the link side lets go of the rom a few link edges after run begins
    repeat (40) @(negedge i_sys_clk);
    chk({o_core_reset_b, o_srom_oe_b, 11'h0, o_state}, {2'b11, 11'h0, ST_RUN});
  endtask

  initial begin
    n_errors = 0;
    comparisons = 0;
    #50us;
    n_errors++;
    print_verdict();
  end

  initial begin
    i_rst_b = 1'b0;
    i_ext_reset_b = 1'b0;
    i_power_good = 1'b1;
    i_srom_present_b = 1'b1;
    i_clk_mode = 3'h0;
    i_irq = 4'h4;
    {i_halt_req, i_pwr_fail_req, i_mcheck_req} = 3'h0;
    {i_bc_ctl, i_tag_dirty, i_tag_valid, i_bcast_or_sys, i_word_ready} = 10'h0;
    repeat (4) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    // mode decode and pass-through rows
    foreach (ROWS[i]) begin
      @(negedge i_sys_clk);
      i_clk_mode = ROWS[i].mode;
      i_bc_ctl = ROWS[i].bc;
      {i_tag_valid, i_tag_dirty} = ROWS[i].bc[1:0];
      i_bcast_or_sys = ROWS[i].bcast;
      {i_mcheck_req, i_pwr_fail_req, i_halt_req} = ROWS[i].req;
      repeat (6) @(negedge i_sys_clk);
      chk(16'({o_clk_cfg.pll_mode, o_clk_cfg.direct_mode}), 16'({ROWS[i].pll, ROWS[i].direct}));
      if (!ROWS[i].pll) chk(16'(o_clk_cfg.equalizer_en), 16'(ROWS[i].mode[0]));
      chk(16'({o_clk_cfg.clkout_gen_rst, o_system_clock_output_rst}), 16'({2{ROWS[i].gen_rst}}));
      chk(16'(o_sync_reqs), 16'(ROWS[i].req));
      chk(16'({o_bc_ctl, o_tag_valid, o_tag_dirty}), 16'({ROWS[i].bc, ROWS[i].bc[1:0]}));
      chk(16'({o_tag_dirty_oe_b, o_tag_valid_oe_b}), 16'({2{~ROWS[i].bcast}}));
    end
    @(negedge i_sys_clk);
    i_clk_mode = 3'h0;
    boot(4'h4, 1'b1, 40);
    boot(4'hf, 1'b0, 30);
    @(negedge i_sys_clk);
    i_word_ready = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    chk(16'(got_q.size()), 16'h2);
    if (got_q.size() == 2) begin
      chk(16'(got_q[0]), 16'({8'ha5, 1'b0}));
      chk(16'(got_q[1]), 16'({8'h3c, 1'b1}));
    end
    // power loss drops the core back into reset
    i_power_good = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    chk(16'(o_core_reset_b), 16'h0);
    i_power_good = 1'b1;
    // mid-run reset returns outputs to their idle values
    i_rst_b = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    chk(16'({o_core_reset_b, o_system_clock_output_rst, o_bc_ctl}), 16'({2'b01, 6'h3f}));
    chk(16'({o_tag_dirty_oe_b, o_tag_valid_oe_b, o_srom_oe_b}), 16'h7);
    print_verdict();
  end
endmodule
`default_nettype wire

// *** tb/srom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// serial boot rom: one bit per high phase of the generated clock, msb first
module srom_model #(
  parameter int unsigned NBITS = 16,
  parameter logic [15:0] IMAGE = 16'ha53c
) (
  // link side
  input  wire logic i_link_clk,
  input  wire logic i_rom_clk,
  input  wire logic i_rom_oe_b,
  output logic      o_rom_data
);
  int unsigned idx;
  logic        shown;

  initial begin
    o_rom_data = 1'b0;
    idx        = 0;
    shown      = 1'b0;
  end

  // bit changes mid high phase, after the rising edge, so it is settled at the fall
  always @(negedge i_link_clk) begin
    if (i_rom_oe_b) begin
      o_rom_data <= ~o_rom_data; // released line shows no stale level
      idx        <= 0;
      shown      <= 1'b0;
    end else if (i_rom_clk && !shown) begin
      o_rom_data <= (idx < NBITS) ? IMAGE[NBITS-1-idx] : ~o_rom_data;
      idx        <= idx + 1;
      shown      <= 1'b1;
    end else if (!i_rom_clk) begin
      shown <= 1'b0;
    end
  end
endmodule
`default_nettype wire
